/* File: hw/single_line_symbol_link.sv */
// Interface joining the master and the receiving device
`timescale 1ns/100ps
interface single_line_symbol_link;
    logic master_line;
    logic master_oe;
    logic dev_line;
    logic ack_return_switch_n;
    logic line;

    // Wire level: device drives during acknowledge, else master
    assign line = !ack_return_switch_n ? dev_line :
        (master_oe ? master_line : 1'b0);

    modport master (
        output master_line,
        output master_oe,
        input line
    );
    modport device (
        output dev_line,
        output ack_return_switch_n,
        input line
    );
endinterface

/* File: hw/single_wire_dac_frame_receiver.sv */
// Device end: symbol decoder, frame assembler and configuration registers
`timescale 1ns/100ps
`include "swl_defs.svh"

// Contract
// - Delimiter before tag clears frame buffer
// - Zero tag targets output code register
// - One tag targets configuration registers
// - Sixteen payload symbols form one code
// - Config frame: high byte address, low data
// - Payload assembled most significant bit first
// - Two parity symbols follow the payload
// - High parity one when ones even
// - Low parity one when ones even
// - Closing delimiter completes the frame
// - Acknowledge directly follows closing delimiter
// - Acknowledge lasts twice low parity duration
// - Each symbol judged alone, no rate
// - Only acknowledge is sent back
// - Fault forces output into alarm band
// - Band chosen by band-select pin
// - Alarm level from alarm registers
// - Valid frames update code or config
// - Symbol duty encodes zero, one, delimiter
// - Line-low idle symbols between frames
// - Device drives line during acknowledge
module single_wire_dac_frame_receiver (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Link
    single_line_symbol_link.device link,
    // Control pins
    input wire logic alarm_band_select_pin_i,
    input wire logic fault_i,
    input wire logic ack_enable_i,
    // Results
    output logic [15:0] output_code_word_o,
    output logic [15:0] loop_drive_code_o,
    output logic [7:0] low_alarm_current_level_o,
    output logic [7:0] high_alarm_current_level_o,
    output logic frame_ok_o,
    output logic frame_err_o
);
    logic [1:0] sync_q;
    logic [1:0] band_sync_q;
    logic prev_q;
    logic [15:0] high_cnt_q;
    logic [15:0] per_cnt_q;
    logic [15:0] last_per_q;
    logic sym_valid;
    swl_pkg::symbol_t sym;
    logic [18:0] shift_q;
    logic [4:0] count_q;
    logic bad_q;
    logic [15:0] code_q;
    logic [7:0] low_alarm_q;
    logic [7:0] high_alarm_q;
    logic ok_q;
    logic err_q;
    logic [16:0] ack_cnt_q;
    logic [15:0] p0_len_q;
    logic [15:0] cur_p0_q;
    logic ack_on_q;
    logic ack_pend_q;
    logic [15:0] drive_q;
    logic hi_par;
    logic lo_par;
    logic frame_good;
    logic ack_return_switch_n_q;
    logic close_end;
    logic sym_end;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_q <= 2'h0;
            band_sync_q <= 2'h0;
        end
        else if (ce_i)
        begin
            sync_q <= {sync_q[0], link.line & ack_return_switch_n_q};
            band_sync_q <= {band_sync_q[0], alarm_band_select_pin_i};
        end
    end

    // ------------------------------------------------------------
    // Symbol measurement
    // ------------------------------------------------------------
    // Symbol ends at each rising edge; a long low ends it as idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_q <= 1'b0;
            high_cnt_q <= 16'h0000;
            per_cnt_q <= 16'h0000;
            last_per_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            prev_q <= sync_q[1];
            if (sym_end || (per_cnt_q == `SWL_TP_MAX))
            begin
                per_cnt_q <= 16'h0001;
                high_cnt_q <= {15'h0000, sync_q[1]};
                last_per_q <= per_cnt_q;
            end
            else
            begin
                per_cnt_q <= per_cnt_q + 16'h0001;
                if (sync_q[1])
                    high_cnt_q <= high_cnt_q + 16'h0001;
            end
        end
    end

    assign sym_valid = sync_q[1] && !prev_q && (per_cnt_q != 16'h0000)
        && !ack_on_q;
    // closing delimiter has no next rise; end it after one period
    assign close_end = (count_q == `SWL_FRAME_BITS) && !sync_q[1]
        && (per_cnt_q >= last_per_q) && !ack_on_q;
    assign sym_end = sym_valid || close_end;

    always_comb
    begin
        logic [18:0] h8;
        logic [18:0] p;
        h8 = {high_cnt_q, 3'h0};
        p = {3'h0, per_cnt_q};
        if (per_cnt_q < `SWL_TP_MIN)
            sym = swl_pkg::SYM_BAD;
        else if (h8 >= p && h8 <= 19'(p * 19'h3))
            sym = swl_pkg::SYM_ZERO;
        else if (h8 >= 19'(p * 19'h5) && h8 <= 19'(p * 19'h7))
            sym = swl_pkg::SYM_ONE;
        else if (h8 >= 19'(p * 19'h3) + 19'h1 && h8 < 19'(p * 19'h5))
            sym = swl_pkg::SYM_DELIM;
        else
            sym = swl_pkg::SYM_BAD;
    end

    // ------------------------------------------------------------
    // Frame assembly
    // ------------------------------------------------------------
    // high slice parity
    assign hi_par = ~^shift_q[18:10];
    assign lo_par = ~^shift_q[9:2];
    // any bad symbol or parity voids frame
    assign frame_good = (count_q == `SWL_FRAME_BITS) && !bad_q
        && (shift_q[1] == hi_par) && (shift_q[0] == lo_par);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shift_q <= 19'h00000;
            count_q <= 5'h00;
            bad_q <= 1'b0;
            cur_p0_q <= 16'h0000;
        end
        else if (ce_i && sym_end)
        begin
            if (sym == swl_pkg::SYM_DELIM)
            begin
                count_q <= 5'h00;
                bad_q <= 1'b0;
            end
            else if (sym == swl_pkg::SYM_BAD)
                bad_q <= 1'b1;
            else if (count_q == `SWL_FRAME_BITS)
                bad_q <= 1'b1;
            else
            begin
                shift_q <= {shift_q[17:0], sym == swl_pkg::SYM_ONE};
                count_q <= count_q + 5'h01;
                if (count_q == `SWL_FRAME_BITS - 5'h01)
                    cur_p0_q <= per_cnt_q;
            end
        end
        else if (ce_i && per_cnt_q == `SWL_TP_MAX)
        begin
            count_q <= 5'h00;
            bad_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            code_q <= 16'h0000;
            low_alarm_q <= `SWL_RST_LOW_ALARM;
            high_alarm_q <= `SWL_RST_HIGH_ALARM;
            ok_q <= 1'b0;
            err_q <= 1'b0;
        end
        else if (ce_i)
        begin
            ok_q <= 1'b0;
            err_q <= 1'b0;
            if (sym_end && sym == swl_pkg::SYM_DELIM
                && count_q == `SWL_FRAME_BITS)
            begin
                ok_q <= frame_good;
                err_q <= !frame_good;
                if (frame_good && !shift_q[18])
                    code_q <= shift_q[17:2];
                if (frame_good && shift_q[18])
                begin
                    if (shift_q[17:10] == `SWL_ADDR_LOW_ALARM)
                        low_alarm_q <= shift_q[9:2];
                    if (shift_q[17:10] == `SWL_ADDR_HIGH_ALARM)
                        high_alarm_q <= shift_q[9:2];
                end
            end
            else if (sym_end && count_q == `SWL_FRAME_BITS
                && sym != swl_pkg::SYM_DELIM)
                err_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge return
    // ------------------------------------------------------------
    // starts right after closing delimiter
    // ack pulse is the only return data
    // switch low and drive the line
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_on_q <= 1'b0;
            ack_pend_q <= 1'b0;
            ack_cnt_q <= 17'h00000;
            p0_len_q <= 16'h0000;
            ack_return_switch_n_q <= 1'b1;
        end
        else if (ce_i)
        begin
            ack_pend_q <= 1'b0;
            if (ok_q && ack_enable_i)
            begin
                ack_on_q <= 1'b1;
                ack_return_switch_n_q <= 1'b0;
                ack_cnt_q <= 17'h00000;
                p0_len_q <= cur_p0_q;
            end
            else if (ack_on_q)
            begin
                ack_cnt_q <= ack_cnt_q + 17'h00001;
                if (ack_cnt_q == {p0_len_q, 1'b0} - 17'h00001)
                begin
                    ack_on_q <= 1'b0;
                    ack_return_switch_n_q <= 1'b1;
                    ack_pend_q <= 1'b1;
                end
            end
        end
    end

    // Pulse high between the midpoints of the two periods
    assign link.dev_line = ack_on_q && (ack_cnt_q >= {1'b0, p0_len_q} >> 1)
        && (ack_cnt_q < {1'b0, p0_len_q} + ({1'b0, p0_len_q} >> 1));
    assign link.ack_return_switch_n = ack_return_switch_n_q;

    // ------------------------------------------------------------
    // Alarm band steering
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drive_q <= 16'h0000;
        else if (ce_i)
            drive_q <= !fault_i ? code_q :
                (band_sync_q[1] ? {high_alarm_q, 8'h00}
                                : {low_alarm_q, 8'h00});
    end

    assign output_code_word_o = code_q;
    assign loop_drive_code_o = drive_q;
    assign low_alarm_current_level_o = low_alarm_q;
    assign high_alarm_current_level_o = high_alarm_q;
    assign frame_ok_o = ok_q;
    assign frame_err_o = err_q;
endmodule

/* File: hw/single_wire_link_master.sv */
// Master end: Wishbone-controlled frame transmitter
`timescale 1ns/100ps
`include "swl_defs.svh"

module single_wire_link_master (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link
    single_line_symbol_link.master link
);
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_SEND = 2'h1,
        M_ACK = 2'h3
    } mstate_t;

    mstate_t state_q;
    logic [22:0] frame_q;
    logic [4:0] idx_q;
    logic [15:0] tick_q;
    logic [15:0] hi_len;
    logic want_ack_q;
    logic got_ack_q;
    logic seen_hi_q;
    logic [1:0] rx_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic start;
    logic [8:0] hi_slice;
    logic [7:0] lo_slice;

    assign start = cyc_i && stb_i && we_i && ack_q
        && adr_i == `SWL_REG_CMD && state_q == M_IDLE && ce_i
        && (&sel_i[2:0]);
    assign hi_slice = {dat_i[`SWL_REG_CMD_TAG_BIT], dat_i[15:8]};
    assign lo_slice = dat_i[7:0];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else if (ce_i)
        begin
            ack_q <= cyc_i && stb_i && !ack_q;
            rdat_q <= 32'h00000000;
            if (adr_i == `SWL_REG_STATUS)
                rdat_q <= {state_q != M_IDLE, 29'h0, want_ack_q, got_ack_q};
        end
    end
    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    // ------------------------------------------------------------
    // Frame sender: D, tag, payload, parities, D
    // ------------------------------------------------------------
    // Symbol codes: 2'h0 zero, 2'h1 one, 2'h2 delimiter
    assign hi_len = frame_q[22] ? 16'(`SWL_TX_PERIOD >> 1) :
        (frame_q[21] ? 16'((`SWL_TX_PERIOD * 3) >> 2)
                     : 16'(`SWL_TX_PERIOD >> 2));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= M_IDLE;
            frame_q <= 23'h000000;
            idx_q <= 5'h00;
            tick_q <= 16'h0000;
            want_ack_q <= 1'b0;
            got_ack_q <= 1'b0;
            seen_hi_q <= 1'b0;
            rx_q <= 2'h0;
        end
        else if (ce_i)
        begin
            rx_q <= {rx_q[0], link.line};
            case (state_q)
                M_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= M_SEND;
                        frame_q <= {1'b1, 1'b0, hi_slice, lo_slice,
                            ~^hi_slice, ~^lo_slice, 2'h0};
                        idx_q <= 5'h00;
                        tick_q <= 16'h0000;
                        want_ack_q <= dat_i[`SWL_REG_CMD_ACK_BIT];
                        got_ack_q <= 1'b0;
                    end
                end
                M_SEND:
                begin
                    tick_q <= tick_q + 16'h0001;
                    if (tick_q == `SWL_TX_PERIOD - 16'h0001)
                    begin
                        tick_q <= 16'h0000;
                        idx_q <= idx_q + 5'h01;
                        frame_q <= (idx_q == 5'h13) ?
                            {2'h2, 21'h0} : {frame_q[21:0], 1'b0} & 23'h3fffff;
                        if (idx_q == 5'h00)
                            frame_q <= {1'b0, frame_q[20:0], 1'b0};
                        if (idx_q == 5'h14)
                            state_q <= want_ack_q ? M_ACK : M_IDLE;
                        seen_hi_q <= 1'b0;
                    end
                end
                M_ACK:
                begin
                    tick_q <= tick_q + 16'h0001;
                    if (rx_q[1])
                        seen_hi_q <= 1'b1;
                    if (tick_q == {`SWL_TX_PERIOD, 1'b0} - 16'h0001)
                    begin
                        got_ack_q <= seen_hi_q;
                        state_q <= M_IDLE;
                    end
                end
                default:
                    state_q <= M_IDLE;
            endcase
        end
    end

    assign link.master_line = (state_q == M_SEND) && (tick_q < hi_len);
    assign link.master_oe = state_q != M_ACK;
endmodule

/* File: hw/swl_defs.svh */
// Constants for the single-wire symbol link and frame receiver
`ifndef SWL_DEFS_SVH
`define SWL_DEFS_SVH

// Symbol period limits, in clock cycles
`define SWL_TP_MIN 16'h0010
`define SWL_TP_MAX 16'hfff0
// Master symbol period, in clock cycles
`define SWL_TX_PERIOD 16'h0040

// Frame layout
`define SWL_FRAME_BITS 5'h13
`define SWL_PAYLOAD_BITS 5'h10

// Configuration register addresses and reset values
`define SWL_ADDR_LOW_ALARM 8'h04
`define SWL_ADDR_HIGH_ALARM 8'h05
`define SWL_RST_LOW_ALARM 8'h24
`define SWL_RST_HIGH_ALARM 8'he8

// Bus register offsets of the master
`define SWL_REG_CMD 4'h0
`define SWL_REG_STATUS 4'h4
`define SWL_REG_CMD_BUSY_BIT 31
`define SWL_REG_CMD_TAG_BIT 16
`define SWL_REG_CMD_ACK_BIT 17

`endif

/* File: hw/swl_pkg.sv */
// Types used by the receiving end of the symbol link
package swl_pkg;
    typedef enum logic [2:0] {
        SYM_ZERO = 3'h0,
        SYM_ONE = 3'h1,
        SYM_DELIM = 3'h3,
        SYM_ACK = 3'h2,
        SYM_BAD = 3'h6
    } symbol_t;
endpackage

/* File: verification/swl_link_checker.sv */
// Protocol assertions on the signals of one symbol link
`timescale 1ns/100ps
module swl_link_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic master_line,
    input wire logic master_oe,
    input wire logic dev_line,
    input wire logic ack_return_switch_n,
    input wire logic line
);
    logic [15:0] hi_q;
    logic [15:0] rise_q;
    logic [15:0] ackc_q;

    // ----------------------------------------
    // Pulse, period and acknowledge counters
    // ----------------------------------------
    always_ff @(posedge clk_i)
        hi_q <= (rst_i || !master_line) ? 16'h0000 : hi_q + 16'h0001;
    always_ff @(posedge clk_i)
        if (rst_i)
            rise_q <= 16'hffff;
        else if (master_line && hi_q == 16'h0000)
            rise_q <= 16'h0000;
        else if (rise_q != 16'hffff)
            rise_q <= rise_q + 16'h0001;
    always_ff @(posedge clk_i)
        ackc_q <= ack_return_switch_n ? 16'h0000 : ackc_q + 16'h0001;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_reset_quiet;
        $fell(rst_i) |-> ack_return_switch_n && !master_line;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("link not quiet after reset");
    property p_pulse_max;
        master_line |-> hi_q <= 16'h002f;
    endproperty
    a_pulse_max: assert property (p_pulse_max)
        else $error("symbol high time too long");
    property p_pulse_width;
        $fell(master_line) |-> hi_q inside {16'h0010, 16'h0020, 16'h0030};
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("symbol duty not a legal symbol");
    property p_period_min;
        master_line && hi_q == 16'h0000 |-> rise_q >= 16'h000f;
    endproperty
    a_period_min: assert property (p_period_min)
        else $error("symbol period below minimum");
    property p_oe_drive;
        master_line |-> master_oe;
    endproperty
    a_oe_drive: assert property (p_oe_drive)
        else $error("master line high while not driving");
    property p_ack_master_quiet;
        !ack_return_switch_n [*8] |-> !master_line && line == dev_line;
    endproperty
    a_ack_master_quiet: assert property (p_ack_master_quiet)
        else $error("master active during acknowledge");
    property p_ack_after_delim;
        $fell(ack_return_switch_n) |-> rise_q <= 16'h0050;
    endproperty
    a_ack_after_delim: assert property (p_ack_after_delim)
        else $error("acknowledge not right after closing symbol");
    property p_ack_min_len;
        $rose(ack_return_switch_n) |-> ackc_q >= 16'h0070;
    endproperty
    a_ack_min_len: assert property (p_ack_min_len)
        else $error("acknowledge too short");
    property p_ack_max_len;
        !ack_return_switch_n |-> ackc_q <= 16'h0090;
    endproperty
    a_ack_max_len: assert property (p_ack_max_len)
        else $error("acknowledge too long");
endmodule

/* File: verification/testbench.sv */
// Self-checking bench joining master and device over the link
`timescale 1ns/100ps
`include "swl_defs.svh"
module testbench;
    localparam int P = 64;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dout;
    logic [31:0] rdat;
    logic wack;
    logic fault = 1'b0;
    logic band = 1'b0;
    logic ack_en = 1'b0;
    logic [15:0] code1, drive1, code2;
    logic [7:0] low1, high1;
    logic ok1, err2;
    logic [41:0] sym_q = 42'h0;
    int errors = 0;
    int num_checks = 0;
    int ok_n = 0;
    int err_n = 0;
    int ack_n = 0;
    int sw2_n = 0;
    int hi_n = 0;

    single_line_symbol_link link1 ();
    single_line_symbol_link link2 ();
    single_wire_link_master i_single_wire_link_master (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dout), .ack_o(wack),
        .link(link1));
    single_wire_dac_frame_receiver i_single_wire_dac_frame_receiver (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link1),
        .alarm_band_select_pin_i(band), .fault_i(fault),
        .ack_enable_i(ack_en), .output_code_word_o(code1),
        .loop_drive_code_o(drive1), .low_alarm_current_level_o(low1),
        .high_alarm_current_level_o(high1), .frame_ok_o(ok1),
        .frame_err_o());
    single_wire_dac_frame_receiver i_single_wire_dac_frame_receiver_2 (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link2),
        .alarm_band_select_pin_i(band), .fault_i(fault),
        .ack_enable_i(ack_en), .output_code_word_o(code2),
        .loop_drive_code_o(), .low_alarm_current_level_o(),
        .high_alarm_current_level_o(), .frame_ok_o(), .frame_err_o(err2));
    swl_link_checker i_swl_link_checker (.clk_i(clk_i), .rst_i(rst_i),
        .master_line(link1.master_line), .master_oe(link1.master_oe),
        .dev_line(link1.dev_line), .line(link1.line),
        .ack_return_switch_n(link1.ack_return_switch_n));

    always #2 clk_i = ~clk_i;

    // ----------------------------------------
    // Link monitor: symbols, acknowledge, flags
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (ok1 === 1'b1) ok_n <= ok_n + 1;
        if (err2 === 1'b1) err_n <= err_n + 1;
        if (link2.ack_return_switch_n === 1'b0) sw2_n <= sw2_n + 1;
        if (cyc && we && adr == `SWL_REG_CMD) ack_n <= 0;
        else if (link1.ack_return_switch_n === 1'b0) ack_n <= ack_n + 1;
        if (link1.line === 1'b1 && link1.ack_return_switch_n === 1'b1)
            hi_n <= hi_n + 1;
        else if (hi_n != 0)
        begin
            sym_q <= {sym_q[39:0], (hi_n * 8 <= 3 * P) ? 2'h0 :
                (hi_n * 8 >= 5 * P) ? 2'h1 : 2'h3};
            hi_n <= 0;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        @(posedge clk_i);
        while (wack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
        begin
            errors++;
            print_verdict();
        end
        rdat = dout;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic send(input logic tag, input logic [15:0] p, input logic ak);
        int n;
        wb(1'b1, `SWL_REG_CMD, {14'h0000, ak, tag, p});
        n = 0;
        rdat = 32'h80000000;
        while (rdat[31] !== 1'b0 && n < 1000)
        begin
            wb(1'b0, `SWL_REG_STATUS, 32'h0);
            n++;
        end
        if (n == 1000)
        begin
            errors++;
            print_verdict();
        end
        // Let the device finish decoding the closing symbol
        repeat (8) @(posedge clk_i);
    endtask

    function automatic logic [41:0] exp_syms(input logic t, input logic [15:0] p);
        logic [41:0] e;
        e = {38'h0, 2'h3, 1'b0, t};
        for (int i = 15; i >= 0; i--) e = {e[39:0], 1'b0, p[i]};
        e = {e[39:0], 1'b0, ~^{t, p[15:8]}};
        e = {e[39:0], 1'b0, ~^p[7:0]};
        return {e[39:0], 2'h3};
    endfunction

    task automatic bb(input logic [1:0] k);
        int h;
        h = (k == 2'h0) ? 16 : (k == 2'h1) ? 48 : 32;
        link2.master_line <= 1'b1;
        repeat (h) @(posedge clk_i);
        link2.master_line <= 1'b0;
        repeat (P - h) @(posedge clk_i);
    endtask

    task automatic bb_frame(input logic [15:0] p, input logic bad);
        bb(2'h3);
        bb(2'h0);
        for (int i = 15; i >= 0; i--) bb({1'b0, p[i]});
        bb({1'b0, ~^{1'b0, p[15:8]}});
        bb({1'b0, bad ^ ~^p[7:0]});
        bb(2'h3);
        link2.master_oe <= 1'b0;
        repeat (3 * P) @(posedge clk_i);
        link2.master_oe <= 1'b1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_dac(input logic [15:0] p, input logic ak);
        int n0;
        n0 = ok_n;
        ack_en <= ak;
        send(1'b0, p, ak);
        chk(code1, p);
        chk(sym_q, exp_syms(1'b0, p));
        chk(ok_n - n0, 1);
        chk(rdat[0], ak);
        chk(ack_n >= 112 && ack_n <= 144, ak);
        chk(ack_n == 0, !ak);
    endtask

    task automatic t_cfg;
        ack_en <= 1'b0;
        send(1'b1, 16'h045a, 1'b0);
        chk(low1, 8'h5a);
        chk(sym_q, exp_syms(1'b1, 16'h045a));
        send(1'b1, 16'h0581, 1'b0);
        chk({high1, code1}, 24'h818001);
        send(1'b1, 16'h0733, 1'b0);
        chk({low1, high1}, 16'h5a81);
    endtask

    task automatic t_alarm;
        fault <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(drive1, 16'h5a00);
        band <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(drive1, 16'h8100);
        fault <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(drive1, 16'h8001);
    endtask

    task automatic t_bad;
        int e0;
        int s0;
        link2.master_oe <= 1'b1;
        ack_en <= 1'b1;
        bb(2'h3);
        bb(2'h0);
        repeat (5) bb(2'h1);
        bb_frame(16'h1234, 1'b0);
        chk(code2, 16'h1234);
        chk(sw2_n > 100, 1);
        e0 = err_n;
        s0 = sw2_n;
        bb_frame(16'hbeef, 1'b1);
        chk(code2, 16'h1234);
        chk(sw2_n - s0, 0);
        chk(err_n - e0, 1);
    endtask

    task automatic print_verdict;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        link2.master_line = 1'b0;
        link2.master_oe = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({code1, low1, high1, drive1}, 48'h000024e80000);
        t_dac(16'ha5c3, 1'b0);
        t_dac(16'h8001, 1'b1);
        t_cfg();
        t_alarm();
        t_bad();
        print_verdict();
    end

    initial
    begin
        repeat (60000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule
